// ### core/edge_enc_pkg.sv
// Shared constants and types for the edge and encoder counter channel.
// Assumes a 32-bit AHB-Lite register bus and a single 25 MHz clock.
`default_nettype none
package edge_enc_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] count_offset = 8'h08;
  localparam logic [7:0] reload_offset = 8'h0c;
  localparam logic [7:0] fifo_offset = 8'h10;
  localparam logic [7:0] cmd_offset = 8'h14;
  // Command bit positions, then FIFO depth, count width and reload reset value
  localparam int cmd_arm_bit = 0;
  localparam int cmd_disarm_bit = 1;
  localparam int fifo_depth = 16;
  localparam int count_width = 32;
  localparam logic [31:0] reload_reset = 32'h0000_0000;

  typedef enum logic [1:0] {
    single_edge_decode = 2'b00,
    double_edge_decode = 2'b01,
    four_edge_decode = 2'b10
  } decode_type;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_armed = 2'b01,
    st_snap = 2'b11
  } run_type;

  typedef struct packed {
    logic sample_rising;
    logic index_enable;
    decode_type decode;
    logic pause_level;
    logic pause_from_gate;
    logic pause_enable;
    logic count_gate_enable;
    logic buffered;
    logic count_rising;
    logic encoder_mode;
  } ctrl_type;
  localparam ctrl_type ctrl_reset = 11'h402;

  typedef struct packed {
    logic overflow;
    logic fifo_full;
    logic fifo_empty;
    logic armed;
  } status_type;

  typedef struct packed {
    logic edge_in;
    logic gate;
    logic pause;
    logic sample;
    logic phase_a;
    logic phase_b;
    logic index;
  } pins_type;
  localparam int pin_count = 7;
endpackage
`default_nettype wire

// ### core/edge_enc_counter.sv
// Edge counter and quadrature decoder with sample FIFO, AHB-Lite slave.
// Assumes asynchronous pins, one 25 MHz clock and word-only bus access.
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_out_valid = (wr_q != rd_q);
  assign o_in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign o_out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (i_flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule

module edge_enc_counter #(
  parameter int CNT_W = edge_enc_pkg::count_width,
  parameter int DEPTH = edge_enc_pkg::fifo_depth
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  // Signal source and encoder pins
  input wire logic i_edge_in,
  input wire logic i_gate,
  input wire logic i_pause,
  input wire logic i_sample_clk,
  input wire logic i_phase_a,
  input wire logic i_phase_b,
  input wire logic i_index,
  // Status
  output logic o_armed
);
  localparam int NP = edge_enc_pkg::pin_count;

  // Reset release
  logic [1:0] rst_q;
  wire rst_n = rst_q[1];
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  // Pin synchronisers; only the second stage and its delayed copy are read
  edge_enc_pkg::pins_type pins_raw;
  edge_enc_pkg::pins_type pins_s;
  edge_enc_pkg::pins_type pins_p;
  logic [NP-1:0] meta_q;
  logic [NP-1:0] sync_q;
  logic [NP-1:0] prev_q;
  assign pins_raw = {i_edge_in, i_gate, i_pause, i_sample_clk, i_phase_a, i_phase_b, i_index};
  assign pins_s = sync_q;
  assign pins_p = prev_q;

  for (genvar g = 0; g < NP; g++) begin : g_sync
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
        prev_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= pins_raw[g];
        sync_q[g] <= meta_q[g];
        prev_q[g] <= sync_q[g];
      end
    end
  end

  function automatic logic edge_of(input logic now, input logic was, input logic rising);
    edge_of = rising ? (now && !was) : (!now && was);
  endfunction

  // Registers
  edge_enc_pkg::ctrl_type ctrl_q;
  edge_enc_pkg::run_type state_q;
  edge_enc_pkg::run_type state_d;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic overflow_q;

  // Bus address phase capture
  logic [7:0] addr_q;
  logic wr_pend_q;
  logic [31:0] rdata_q;
  logic ready_q;
  wire take = i_hsel && i_htrans[1] && i_hready;
  wire rd_take = take && !i_hwrite;
  wire [7:0] addr_w = {i_haddr[7:2], 2'b00};
  wire wr_now = wr_pend_q;
  wire wr_ctrl = wr_now && (addr_q == edge_enc_pkg::ctrl_offset);
  wire wr_reload = wr_now && (addr_q == edge_enc_pkg::reload_offset);
  wire wr_cmd = wr_now && (addr_q == edge_enc_pkg::cmd_offset);
  wire arm_cmd = wr_cmd && i_hwdata[edge_enc_pkg::cmd_arm_bit];
  wire disarm_cmd = wr_cmd && i_hwdata[edge_enc_pkg::cmd_disarm_bit];
  wire rd_count = rd_take && (addr_w == edge_enc_pkg::count_offset);
  wire rd_fifo = rd_take && (addr_w == edge_enc_pkg::fifo_offset);
  wire armed = (state_q == edge_enc_pkg::st_armed);
  wire counting = armed || (state_q == edge_enc_pkg::st_snap);

  // Pause and gate qualification
  wire pause_src = ctrl_q.pause_from_gate ? pins_s.gate : pins_s.pause;
  wire paused = ctrl_q.pause_enable && (pause_src == ctrl_q.pause_level);
  wire gate_ok = !ctrl_q.count_gate_enable || pins_s.gate;
  wire run = counting && !paused;

  // Plain edge counting
  wire edge_hit = edge_of(pins_s.edge_in, pins_p.edge_in, ctrl_q.count_rising);

  // Quadrature decode
  wire a_n = pins_s.phase_a;
  wire b_n = pins_s.phase_b;
  wire a_chg = a_n ^ pins_p.phase_a;
  wire b_chg = b_n ^ pins_p.phase_b;
  wire a_rise = a_chg && a_n;
  wire a_fall = a_chg && !a_n;
  logic q_step;
  logic q_up;
  always_comb begin
    q_step = 1'b0;
    q_up = 1'b0;
    unique case (ctrl_q.decode)
      edge_enc_pkg::single_edge_decode: begin
        q_step = (a_rise || a_fall) && !b_chg && !b_n;
        q_up = a_rise;
      end
      edge_enc_pkg::double_edge_decode: begin
        q_step = a_chg && !b_chg;
        q_up = a_n ^ b_n;
      end
      edge_enc_pkg::four_edge_decode: begin
        q_step = a_chg ^ b_chg;
        q_up = a_n ^ pins_p.phase_b;
      end
      default: begin
        q_step = 1'b0;
        q_up = 1'b0;
      end
    endcase
  end
  wire index_hit = ctrl_q.encoder_mode && ctrl_q.index_enable &&
                   edge_of(pins_s.index, pins_p.index, 1'b1);

  // Next count
  always_comb begin
    count_d = count_q;
    if (arm_cmd || state_q == edge_enc_pkg::st_idle) begin
      count_d = '0;
    end else if (run && index_hit) begin
      count_d = reload_q;
    end else if (run && ctrl_q.encoder_mode && q_step) begin
      count_d = q_up ? count_q + CNT_W'(1) : count_q - CNT_W'(1);
    end else if (run && !ctrl_q.encoder_mode && edge_hit && gate_ok) begin
      count_d = count_q + CNT_W'(1);
    end
  end

  // Run state: idle, armed, or a one-cycle window around an unarmed read
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      edge_enc_pkg::st_idle: begin
        if (arm_cmd) begin
          state_d = edge_enc_pkg::st_armed;
        end else if (rd_count) begin
          state_d = edge_enc_pkg::st_snap;
        end
      end
      edge_enc_pkg::st_armed: begin
        if (disarm_cmd) begin
          state_d = edge_enc_pkg::st_idle;
        end
      end
      edge_enc_pkg::st_snap: begin
        state_d = edge_enc_pkg::st_idle;
      end
      default: begin
        state_d = edge_enc_pkg::st_idle;
      end
    endcase
  end

  // Sample clock capture into the FIFO; the clock is only ever a pin
  wire sample_hit = armed && ctrl_q.buffered &&
                    edge_of(pins_s.sample, pins_p.sample, ctrl_q.sample_rising);
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [CNT_W-1:0] fifo_out_data;

  sample_fifo #(
    .WIDTH(CNT_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_flush(arm_cmd),
    .i_in_valid(sample_hit),
    .o_in_ready(fifo_in_ready),
    .i_in_data(count_q),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(rd_fifo),
    .o_out_data(fifo_out_data)
  );

  // A full FIFO drops the sample; the drop is flagged until the next arm
  wire overflow_set = sample_hit && !fifo_in_ready;

  edge_enc_pkg::status_type status_w;
  assign status_w = '{overflow: overflow_q, fifo_full: !fifo_in_ready,
                      fifo_empty: !fifo_out_valid, armed: armed};

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_w)
      edge_enc_pkg::ctrl_offset: rd_mux = 32'(ctrl_q);
      edge_enc_pkg::status_offset: rd_mux = 32'(status_w);
      edge_enc_pkg::count_offset: rd_mux = 32'(count_q);
      edge_enc_pkg::reload_offset: rd_mux = 32'(reload_q);
      edge_enc_pkg::fifo_offset: rd_mux = fifo_out_valid ? 32'(fifo_out_data) : 32'h0000_0000;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  wire snap_read = rd_count && (state_q == edge_enc_pkg::st_idle) && !arm_cmd;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= edge_enc_pkg::st_idle;
      count_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= edge_enc_pkg::ctrl_reset;
      reload_q <= CNT_W'(edge_enc_pkg::reload_reset);
      overflow_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= edge_enc_pkg::ctrl_type'(i_hwdata[$bits(edge_enc_pkg::ctrl_type)-1:0]);
      end
      if (wr_reload) begin
        reload_q <= i_hwdata[CNT_W-1:0];
      end
      // Set wins over the clear made by arming
      overflow_q <= overflow_set || (overflow_q && !arm_cmd);
    end
  end

  // Bus slave: reads answer in the first data phase cycle, except an
  // unarmed count read, which inserts one wait state for its window
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 8'h00;
      wr_pend_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b1;
      o_armed <= 1'b0;
    end else begin
      o_armed <= (state_d == edge_enc_pkg::st_armed);
      wr_pend_q <= take && i_hwrite;
      if (take) begin
        addr_q <= addr_w;
      end
      if (snap_read) begin
        ready_q <= 1'b0;
      end else if (state_q == edge_enc_pkg::st_snap) begin
        ready_q <= 1'b1;
        rdata_q <= 32'(count_d);
      end else if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign o_hreadyout = ready_q;
  assign o_hrdata = rdata_q;
  assign o_hresp = 1'b0;
endmodule
`default_nettype wire

// ### tb/edge_enc_monitor.sv
// Checker for the counter channel bus timing and arm state.
// Assumes one slave, so i_hready is the slave's own hreadyout.
`default_nettype none
module edge_enc_monitor (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_armed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic take = i_hsel & i_htrans[1] & i_hready;
  wire logic cnt_rd = take & !i_hwrite & (i_haddr[7:0] == edge_enc_pkg::count_offset);
  wire logic cmd_wr = take & i_hwrite & (i_haddr[7:0] == edge_enc_pkg::cmd_offset);
  // Marks the data phase of a command write, when hwdata is valid
  logic cmd_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) cmd_q <= 1'b0;
    else cmd_q <= cmd_wr;
  end
  sequence one_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  AST_UNARMED_READ: assert property (cnt_rd && !o_armed |=> one_wait)
    else $error("unarmed count read without one wait");
  AST_ARMED_READ: assert property (cnt_rd && o_armed |=> o_hreadyout)
    else $error("armed count read stalled");
  AST_OTHER_READ: assert property (take && !cnt_rd |=> o_hreadyout)
    else $error("transfer stalled");
  AST_WAIT_ONE: assert property (!o_hreadyout |=> o_hreadyout)
    else $error("wait longer than one cycle");
  AST_ARM: assert property (cmd_q && i_hwdata[0] |=> o_armed)
    else $error("arm command ignored");
  AST_DISARM: assert property (cmd_q && i_hwdata[1:0] == 2'b10 |=> !o_armed)
    else $error("disarm command ignored");
  AST_ARM_STEADY: assert property (!cmd_q |=> $stable(o_armed))
    else $error("armed changed without command");
  AST_OKAY: assert property (o_hresp == 1'b0)
    else $error("response not okay");
endmodule
bind edge_enc_counter edge_enc_monitor mon (.i_clk, .i_arst_n, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_armed);
`default_nettype wire

// ### tb/enc_source_model.sv
// Signal source and quadrature encoder driving the counter pins.
// Assumes the bench clock; every level stands HOLD cycles, at least two.
`default_nettype none
module enc_source_model #(
  parameter int HOLD = 4
) (
  input wire logic i_clk,
  output var edge_enc_pkg::pins_type o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // States {a,b} with A leading: 10 11 01 00
  localparam logic [7:0] fwd_seq = 8'hb4;
  initial o_pins = '0;
  task automatic wait_hold();
    repeat (HOLD) @(posedge i_clk);
  endtask
  task automatic set_pins(input logic e, input logic g, input logic p);
    o_pins.edge_in <= e;
    o_pins.gate <= g;
    o_pins.pause <= p;
    wait_hold();
  endtask
  task automatic edges(input int n);
    repeat (n) begin
      set_pins(1'b1, o_pins.gate, o_pins.pause);
      set_pins(1'b0, o_pins.gate, o_pins.pause);
    end
  endtask
  // One phase moves at a time; reverse swaps the phases so B leads
  task automatic quad(input int cycles, input logic fwd);
    logic [1:0] st;
    repeat (cycles) for (int i = 0; i < 4; i++) begin
      st = fwd_seq[7 - 2 * i -: 2];
      {o_pins.phase_a, o_pins.phase_b} <= fwd ? st : {st[0], st[1]};
      wait_hold();
    end
  endtask
  // Sample clock only ticks on request, at one fixed spacing
  task automatic sample_tick();
    o_pins.sample <= 1'b1;
    wait_hold();
    o_pins.sample <= 1'b0;
    wait_hold();
  endtask
  task automatic pulse_index();
    o_pins.index <= 1'b1;
    wait_hold();
    o_pins.index <= 1'b0;
    wait_hold();
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the edge and encoder counter channel.
// Assumes the source model drives the pins and this bench is the bus master.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] a_ctrl = edge_enc_pkg::ctrl_offset;
  localparam logic [7:0] a_stat = edge_enc_pkg::status_offset;
  localparam logic [7:0] a_cnt = edge_enc_pkg::count_offset;
  localparam logic [7:0] a_rld = edge_enc_pkg::reload_offset;
  localparam logic [7:0] a_fifo = edge_enc_pkg::fifo_offset;
  localparam logic [7:0] a_cmd = edge_enc_pkg::cmd_offset;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] hsize = 3'b000;
  logic [31:0] rd;
  logic resp;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic armed;
  edge_enc_pkg::pins_type pins;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  edge_enc_counter DUT (
    .i_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_edge_in(pins.edge_in), .i_gate(pins.gate), .i_pause(pins.pause),
    .i_sample_clk(pins.sample), .i_phase_a(pins.phase_a), .i_phase_b(pins.phase_b),
    .i_index(pins.index), .o_armed(armed));
  enc_source_model src (.i_clk(clk), .o_pins(pins));
  initial forever #20 clk = ~clk;
  // Whole run needs about a thousand cycles; a hang is cut off well past that
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    resp = hresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    n_compared++;
    if (resp !== 1'b0) begin
      bad_count++;
      $display("BAD hresp expected 0 seen %b", resp);
    end
    n_compared++;
    if (rd !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, rd);
    end
  endtask
  task automatic arm(input logic [31:0] ctrl);
    xfer(1'b1, a_ctrl, ctrl);
    xfer(1'b1, a_cmd, 32'h0000_0001);
  endtask
  task automatic t_reset();
    rchk(a_ctrl, 32'h0000_0402, "ctrl");
    rchk(a_stat, 32'h0000_0002, "status");
    rchk(a_rld, 32'h0000_0000, "reload");
    rchk(8'h18, 32'h0000_0000, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_edges();
    for (int p = 0; p < 2; p++) begin
      arm(p ? 32'h0000_0402 : 32'h0000_0400);
      src.edges(5);
      src.set_pins(1'b1, 1'b0, 1'b0);
      rchk(a_cnt, p ? 32'h0000_0006 : 32'h0000_0005, "count");
      src.set_pins(1'b0, 1'b0, 1'b0);
      rchk(a_cnt, 32'h0000_0006, "total");
    end
    xfer(1'b1, a_cmd, 32'h0000_0002);
    src.edges(3);
    rchk(a_cnt, 32'h0000_0000, "unarmed");
    rchk(a_cnt, 32'h0000_0000, "unarmed again");
    $display("test edges done");
  endtask
  task automatic t_pause();
    for (int g = 0; g < 2; g++) begin
      arm(g ? 32'h0000_0472 : 32'h0000_0452);
      src.set_pins(1'b0, g[0], !g[0]);
      src.edges(3);
      src.set_pins(1'b0, 1'b0, 1'b0);
      src.edges(2);
      rchk(a_cnt, 32'h0000_0002, "paused count");
    end
    // Gate low blocks the first three edges, gate high passes the last two
    arm(32'h0000_040a);
    src.edges(3);
    src.set_pins(1'b0, 1'b1, 1'b0);
    src.edges(2);
    rchk(a_cnt, 32'h0000_0002, "gated count");
    src.set_pins(1'b0, 1'b0, 1'b0);
    $display("test pause done");
  endtask
  task automatic t_quad();
    for (int m = 0; m < 3; m++) begin
      arm(32'h0000_0401 | 32'(m << 7));
      src.quad(2, 1'b1);
      rchk(a_cnt, 32'(2 << m), "forward");
      src.quad(1, 1'b0);
      rchk(a_cnt, 32'(1 << m), "reverse");
    end
    $display("test quadrature done");
  endtask
  task automatic t_index();
    xfer(1'b1, a_rld, 32'h0000_0064);
    arm(32'h0000_0701);
    src.quad(1, 1'b1);
    src.pulse_index();
    src.quad(1, 1'b1);
    rchk(a_cnt, 32'h0000_0068, "index reload");
    rchk(a_rld, 32'h0000_0064, "reload value");
    $display("test index done");
  endtask
  // The bus stays away while the FIFO fills, so one sample past depth is dropped
  task automatic t_buffer();
    arm(32'h0000_0406);
    for (int i = 0; i <= edge_enc_pkg::fifo_depth; i++) begin
      src.edges(1);
      src.sample_tick();
    end
    rchk(a_stat, 32'h0000_000d, "full status");
    for (int i = 1; i <= edge_enc_pkg::fifo_depth; i++) begin
      rchk(a_fifo, 32'(i), "sample");
    end
    rchk(a_stat, 32'h0000_000b, "drained status");
    rchk(a_fifo, 32'h0000_0000, "empty pop");
    $display("test buffer done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_edges();
    t_pause();
    t_quad();
    t_index();
    t_buffer();
    tally_and_finish();
  end
endmodule
`default_nettype wire
